// File: sar_cfg.svh
`ifndef SAR_CFG_SVH
`define SAR_CFG_SVH

// ----------------------------------------
// sizes
// ----------------------------------------
`define SAR_BITS 12
`define SAR_LEVELS 4096
`define SAR_MSB_IDX 4'hb

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 4
`define STEP_TIME_NS 600
`define STEP_CYC (`STEP_TIME_NS / `CLK_PERIOD_NS)
`define CONV_MAX_NS 9000
`define CONV_MAX_CYC (`CONV_MAX_NS / `CLK_PERIOD_NS)
`define START_MIN_NS 100
`define START_MIN_CYC ((`START_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACQ_MIN_NS 6000
`define ACQ_MIN_CYC ((`ACQ_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_NS 1000
`define SETTLE_CYC ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: sar_pkg.sv
package sar_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RESET = 2'b01,
        ST_CONV = 2'b10
    } state_e;

    // pins from the analog side and the timing controller
    typedef struct packed {
        logic start;
        logic hold;
        logic bipolar;
        logic trunc;
        logic comp;
        logic ext;
    } pins_s;

endpackage : sar_pkg

// File: sar_converter_ctrl.sv
`timescale 1ns/100ps
`include "sar_cfg.svh"

module sar_converter_ctrl (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire sar_pkg::pins_s pin_in,
    output logic [11:0] data_out,
    output logic busy,
    output logic hold_mode,
    output logic bipolar_offset,
    output logic [11:0] dac_code
);

    localparam int CONV_MAX = `CONV_MAX_CYC;
    localparam logic [7:0] STEP_LAST = 8'(`STEP_CYC - 1);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    sar_pkg::pins_s meta_ff;
    sar_pkg::pins_s pin_ff;
    logic start_prev_ff;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_ff <= '0;
            pin_ff <= '0;
            start_prev_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= pin_in;
            pin_ff <= meta_ff;
            start_prev_ff <= pin_ff.start;
        end
    end

    logic fall;
    logic tick;
    logic step;
    sar_pkg::state_e state_ff;
    sar_pkg::state_e nxt_state;
    logic [11:0] sar_ff;
    logic [11:0] nxt_sar;
    logic [3:0] idx_ff;
    logic [3:0] nxt_idx;
    logic [7:0] div_ff;
    logic [7:0] nxt_div;
    logic nxt_busy;
    logic [11:0] nxt_data;

    assign fall = start_prev_ff & ~pin_ff.start;
    assign tick = (div_ff == STEP_LAST);
    // external pulses replace the internal step
    assign step = pin_ff.ext ? fall : tick;

    // ----------------------------------------
    // approximation sequencer
    // ----------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        nxt_sar = sar_ff;
        nxt_idx = idx_ff;
        nxt_div = (state_ff == sar_pkg::ST_IDLE || tick) ? 8'h00 : div_ff + 8'h01;
        if (fall && !(pin_ff.ext && state_ff == sar_pkg::ST_CONV))
        begin
            nxt_div = 8'h00;
            nxt_idx = `SAR_MSB_IDX;
            // first external pulse also sets the msb trial
            if (pin_ff.ext)
            begin
                nxt_state = sar_pkg::ST_CONV;
                nxt_sar = 12'h800;
            end
            else
            begin
                nxt_state = sar_pkg::ST_RESET;
                nxt_sar = 12'h000;
            end
        end
        else
        begin
            case (state_ff)
                sar_pkg::ST_RESET:
                begin
                    if (step)
                    begin
                        nxt_sar[idx_ff] = 1'b1;
                        nxt_state = sar_pkg::ST_CONV;
                    end
                end
                sar_pkg::ST_CONV:
                begin
                    if (step)
                    begin
                        // the trunc line went low, so drop the trial bit and stop
                        if (!pin_ff.trunc)
                        begin
                            nxt_sar[idx_ff] = 1'b0;
                            nxt_state = sar_pkg::ST_IDLE;
                        end
                        else
                        begin
                            // keep the trial bit when input is above dac
                            nxt_sar[idx_ff] = pin_ff.comp;
                            if (idx_ff == 4'h0)
                            begin
                                nxt_state = sar_pkg::ST_IDLE;
                            end
                            else
                            begin
                                nxt_idx = idx_ff - 4'h1;
                                nxt_sar[idx_ff - 4'h1] = 1'b1;
                            end
                        end
                    end
                end
                default:
                begin
                    nxt_state = sar_pkg::ST_IDLE;
                end
            endcase
        end
        // busy through reset phase and conversion
        nxt_busy = (nxt_state != sar_pkg::ST_IDLE);
        // complementary coding; bipolar offset is added on the analog side
        nxt_data = ~nxt_sar;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_ff <= sar_pkg::ST_IDLE;
            sar_ff <= 12'h000;
            idx_ff <= `SAR_MSB_IDX;
            div_ff <= 8'h00;
            busy <= 1'b0;
            data_out <= 12'hfff;
            dac_code <= 12'h000;
        end
        else
        begin
            state_ff <= nxt_state;
            sar_ff <= nxt_sar;
            idx_ff <= nxt_idx;
            div_ff <= nxt_div;
            busy <= nxt_busy;
            data_out <= nxt_data;
            dac_code <= nxt_sar;
        end
    end

    // ----------------------------------------
    // sample-hold and range control
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            hold_mode <= 1'b0;
            bipolar_offset <= 1'b0;
        end
        else
        begin
            hold_mode <= pin_ff.hold;
            bipolar_offset <= pin_ff.bipolar;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [11:0] conv_cyc_ff;
    logic [3:0] steps_ff;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            conv_cyc_ff <= 12'h000;
            steps_ff <= 4'h0;
        end
        else if (fall && !(pin_ff.ext && state_ff == sar_pkg::ST_CONV))
        begin
            conv_cyc_ff <= 12'h000;
            steps_ff <= 4'h0;
        end
        else
        begin
            if (busy && conv_cyc_ff != 12'hfff)
            begin
                conv_cyc_ff <= conv_cyc_ff + 12'h001;
            end
            if (state_ff == sar_pkg::ST_CONV && step)
            begin
                steps_ff <= steps_ff + 4'h1;
            end
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    sequence int_cmd_seq;
        fall && !pin_ff.ext && state_ff == sar_pkg::ST_IDLE;
    endsequence

    sequence reset_phase_seq;
        busy && state_ff == sar_pkg::ST_RESET && dac_code == 12'h000;
    endsequence

    a_fall_starts: assert property (int_cmd_seq |=> reset_phase_seq)
        else $error("falling start did not begin a reset phase");

    a_hold_follows: assert property (hold_mode == $past(pin_ff.hold))
        else $error("hold output does not follow hold input");

    a_result_stable: assert property (!busy && !fall |=> $stable(data_out))
        else $error("result changed without a conversion command");

    a_coding_comp: assert property (busy || data_out == ~dac_code)
        else $error("result is not the complement of the approximation");

    a_busy_ends: assert property ($fell(busy) |-> $past(state_ff) == sar_pkg::ST_CONV)
        else $error("busy fell outside a conversion");

    a_conv_time: assert property (busy && !pin_ff.ext |-> conv_cyc_ff < CONV_MAX)
        else $error("conversion exceeded its maximum time");

    a_sar_steps: assert property (!step && !fall |=> $stable(dac_code))
        else $error("approximation register moved without a step");

    a_step_count: assert property ($fell(busy) && $past(pin_ff.trunc) |-> steps_ff == 4'hc)
        else $error("full conversion did not take twelve resolve steps");

    a_trunc_stop: assert property (state_ff == sar_pkg::ST_CONV && step && !pin_ff.trunc
        && !fall |=> !busy)
        else $error("truncation did not stop the conversion");

endmodule : sar_converter_ctrl

// File: sar_host_model.sv
`timescale 1ns/100ps
// ------
// timing controller and comparator
// ------
module sar_host_model (
    input wire logic sys_clk,
    input wire logic go,
    input wire logic ext,
    input wire logic busy,
    input wire logic [11:0] level,
    input wire logic [11:0] dac_code,
    output logic start,
    output logic hold,
    output logic comp
);
    // ideal comparator, ties at or above count as above
    assign comp = (level >= dac_code);
    initial
    begin
        start = 1'b0;
        hold = 1'b0;
        forever
        begin
            @(posedge sys_clk iff go);
            repeat (1500) @(negedge sys_clk);
            hold = 1'b1;
            repeat (250) @(negedge sys_clk);
            // pulses wide enough, slower than the internal step
            repeat (ext ? 13 : 1)
            begin
                start = 1'b1;
                repeat (25) @(negedge sys_clk);
                start = 1'b0;
                repeat (185) @(negedge sys_clk);
            end
            wait (!busy);
            @(negedge sys_clk);
            hold = 1'b0;
        end
    end
endmodule : sar_host_model

// File: sar_converter_ctrl_tb.sv
`timescale 1ns/100ps
`include "sar_cfg.svh"
module sar_converter_ctrl_tb;
    logic sys_clk, rstn, go, ext, bip, tr, trunc_on, start, hold, comp;
    logic busy, hold_mode, bipolar_offset;
    logic [11:0] level, data_out, dac_code, held;
    logic [15:0] seed;
    int failures = 0;
    int n_compared = 0;
    int cyc = 0;
    int n;
    sar_pkg::pins_s pins;
    assign pins = '{start, hold, bip, tr, comp, ext};
    sar_converter_ctrl sar_converter_ctrl_i (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .pin_in(pins),
        .data_out(data_out),
        .busy(busy),
        .hold_mode(hold_mode),
        .bipolar_offset(bipolar_offset),
        .dac_code(dac_code)
    );
    sar_host_model sar_host_model_i (
        .sys_clk(sys_clk),
        .go(go),
        .ext(ext),
        .busy(busy),
        .level(level),
        .dac_code(dac_code),
        .start(start),
        .hold(hold),
        .comp(comp)
    );
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // ------
    // helpers
    // ------
    // short cycle: tie to bit 3 output only while converting
    always @(negedge sys_clk) tr <= !trunc_on | !busy | data_out[3];
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            failures++;
            test_done();
        end
    end
    task automatic test_done();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done
    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [11:0] want(input logic [11:0] lv, input logic t);
        return ~(t ? (lv & 12'hff0) : lv);
    endfunction : want
    task automatic convert(input logic [11:0] lv, input logic b, input logic x, input logic t);
        @(negedge sys_clk);
        level = lv;
        bip = b;
        ext = x;
        trunc_on = t;
        go = 1'b1;
        @(negedge sys_clk);
        go = 1'b0;
        n = 0;
        while (!busy && n < 3000)
        begin
            @(negedge sys_clk);
            n++;
        end
        check({11'h0, busy}, 12'h1);
        check({10'h0, hold_mode, bipolar_offset}, {10'h0, 1'b1, b});
        n = 0;
        while (busy && n < 4000)
        begin
            @(negedge sys_clk);
            n++;
        end
        check({11'h0, x | (n > 1 && n <= `CONV_MAX_CYC)}, 12'h1);
        check(data_out, want(lv, t));
        check(dac_code, ~want(lv, t));
        held = data_out;
        repeat (300) @(negedge sys_clk);
        check(data_out, held);
        check({11'h0, hold_mode}, 12'h0);
    endtask : convert
    // ------
    // main sequence
    // ------
    initial
    begin
        rstn = 1'b0;
        go = 1'b0;
        ext = 1'b0;
        bip = 1'b0;
        trunc_on = 1'b0;
        level = 12'h000;
        seed = 16'h0025;
        repeat (10) @(negedge sys_clk);
        rstn = 1'b1;
        check(data_out, 12'hfff);
        check({9'h0, busy, hold_mode, bipolar_offset}, 12'h0);
        // corner codes first, then random ones
        convert(12'h000, 1'b0, 1'b0, 1'b0);
        convert(12'hfff, 1'b1, 1'b0, 1'b0);
        convert(12'h7ff, 1'b0, 1'b0, 1'b0);
        convert(12'h800, 1'b1, 1'b0, 1'b0);
        repeat (4)
        begin
            seed = lfsr(seed);
            convert(seed[11:0], seed[12], 1'b0, 1'b0);
        end
        convert(12'ha5c, 1'b0, 1'b0, 1'b1);
        convert(12'h3c6, 1'b1, 1'b1, 1'b0);
        test_done();
    end
endmodule : sar_converter_ctrl_tb
